// *** chg_consts.vh ***
// constants for the charger interrupt and timer register bank
`ifndef CHG_CONSTS_VH
`define CHG_CONSTS_VH

// register offsets
`define CHG_A_BST_MASK   8'h0d
`define CHG_A_DETECT     8'h0e
`define CHG_A_POWER_PATH 8'h21
`define CHG_A_SAFETY_DP  8'h22
`define CHG_A_ICL        8'h23
`define CHG_A_WAKE_IRQ   8'h24
`define CHG_A_WATCHDOG   8'h25
`define CHG_A_STAT_FLAGS 8'h26
`define CHG_A_STAT_MASK  8'h27

// reset values
`define CHG_RST_BST_MASK   8'h00
`define CHG_RST_DETECT     8'h16
`define CHG_RST_POWER_PATH 8'h40
`define CHG_RST_SAFETY_DP  8'h00
`define CHG_RST_ICL        8'h2f
`define CHG_RST_WAKE_IRQ   8'h00
`define CHG_RST_WATCHDOG   8'h13

// field positions
`define CHG_B_DP_RELEASE  7
`define CHG_B_PRI_DETECT  1
`define CHG_B_SEC_DETECT  2
`define CHG_B_IRQ_RELEASE 0
`define CHG_ICL_OFF_CODE  5'h1f
`define CHG_FC_NONE_CODE  3'h7

// time units and clock
`define CHG_CLK_NS        40
`define CHG_MS_NS         1000000
`define CHG_SEC_MS        1000
`define CHG_MIN_MS        60000
`define CHG_HOUR_MS       3600000

// timing figures in their own units
`define CHG_FC_BASE_HRS   4
`define CHG_FC_STEP_HRS   2
`define CHG_WAKE_BASE_S   4
`define CHG_WAKE_LONG_S   120
`define CHG_WDT_BASE_S    1
`define CHG_WDT_SHORT_MS  200
`define CHG_WDT_LONG_MS   500
`define CHG_REMIND_OFF_MS 2
`define CHG_REMIND_WAIT_MS 100

`endif

// *** chg_regs.v ***
// charger interrupt, timer and control register bank behind a two-wire bus
// Function
// R1: boost fault masks, one suppresses
// R2: power path owner select, reset hardware
// R3: dp release write one disconnects source
// R4: dp status zero driven, one released
// R5: fast charge limit 4..16 hours
// R6: precharge limit 30, 45, 60 minutes
// R7: hold pauses safety timers keeping count
// R8: input current code, all ones disables; icl_q is only stored here, no logic acts on the all-ones code
// R9: back charge 0/30/45/60 minutes
// R10: wake period 4s to 8min
// R11: wake enable runs periodic timer
// R12: reminder releases pin 2 ms, reasserts
// R13: pin release bit self clears
// R14: watchdog enable runs, disable clears count
// R15: restore defaults 200/500 ms after expiry
// R16: watchdog period 1/2/4/8 seconds
// R17: temperature zone change flags upper bits
// R18: power good change sets flag
// R19: voltage loop change sets flag
// R20: status mask per flag position
// R21: pin asserted on unmasked flag
// R22: detect start sets running until result
`include "chg_consts.vh"
module chg_regs #(
    parameter       MS_CYCLES = `CHG_MS_NS / `CHG_CLK_NS,
    parameter [6:0] DEV_ADDR  = 7'h2a    // arbitrary bus address
) (
    input  wire       CLK,
    input  wire       RSTN,
    input  wire       SCL,
    input  wire       SDA_I,
    output reg        SDA_O,
    output reg        SDA_OE,
    output reg        IRQ_N,
    input  wire       BT_HOT,
    input  wire       BT_WARM,
    input  wire       BT_COOL,
    input  wire       BT_COLD,
    input  wire       PWR_GOOD,
    input  wire       VREG_ACTIVE,
    input  wire [2:0] BOOST_FAULT,
    input  wire       HW_PP_CTRL,
    input  wire       CHG_PRE,
    input  wire       CHG_FAST,
    input  wire       CHG_TERMINATED,
    input  wire       DET_DONE,
    input  wire [2:0] DET_TYPE,
    output reg        DET_START,
    output reg        PP_CTRL_OUT,
    output reg        DP_SOURCE_ON,
    output reg        SAFETY_EXPIRED,
    output reg        BACK_CHARGE_ON,
    output reg        WAKE_EVENT,
    output reg        WATCHDOG_EXPIRED
);
    localparam [31:0] MS_LAST = MS_CYCLES - 1;
    localparam [7:0] R0E = `CHG_RST_DETECT;
    localparam [7:0] R21 = `CHG_RST_POWER_PATH;
    localparam [7:0] R22 = `CHG_RST_SAFETY_DP;
    localparam [7:0] R24 = `CHG_RST_WAKE_IRQ;
    localparam [7:0] R25 = `CHG_RST_WATCHDOG;
    localparam [7:0] R0D = `CHG_RST_BST_MASK;
    // bus states, one-hot
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_ADDR = 7'h02;
    localparam [6:0] S_AACK = 7'h04;
    localparam [6:0] S_WDAT = 7'h08;
    localparam [6:0] S_WACK = 7'h10;
    localparam [6:0] S_RDAT = 7'h20;
    localparam [6:0] S_RACK = 7'h40;

    reg [6:0]  st_q;
    reg        scl_q, sda_q, done_q, rw_q, first_q;
    reg [2:0]  bitc_q;
    reg [7:0]  sh_q, ptr_q, rdata;
    reg        wr_q, rd_q;
    reg [7:0]  wdat_q, wadr_q;
    // register fields
    reg [2:0]  bmask_q, type_q;
    reg [1:0]  lsel_q;
    reg        det2_q, det1_q, run_q;
    reg        ppsel_q, ppen_q, mivrdis_q;
    reg [3:0]  mivrlvl_q;
    reg        dprel_q, hold_q;
    reg [2:0]  fc_q, wk_q;
    reg [1:0]  prc_q, eoc_q, wdp_q;
    reg [7:0]  icl_q;
    reg        wken_q, rem_q, rel_q, wden_q, wdrst_q;
    reg [5:0]  flags_q, smask_q, prev_q;
    reg        armed_q;
    // timing
    reg [14:0] pre_q;
    reg        tick_q;
    reg [25:0] safe_q, back_q, wake_q, wdt_q, rmd_q;
    reg        wdwait_q, restore_q, pin_rel_q, rmd_off_q, phase_q;
    reg [31:0] fc_lim, pre_lim, back_lim, wake_lim, wdt_lim, rst_lim;

    wire        rise   = SCL & ~scl_q;
    wire        fall   = ~SCL & scl_q;
    wire        start  = SCL & scl_q & sda_q & ~SDA_I;
    wire        stop   = SCL & scl_q & ~sda_q & SDA_I;
    wire        svc    = rd_q & (wadr_q == `CHG_A_STAT_FLAGS);
    wire [5:0]  inputs = {BT_HOT, BT_WARM, BT_COOL, BT_COLD, PWR_GOOD,
                          VREG_ACTIVE};  // see R19
    wire [5:0]  set;
    wire        wr_0e  = wr_q & (wadr_q == `CHG_A_DETECT);
    wire        wr_22  = wr_q & (wadr_q == `CHG_A_SAFETY_DP);
    wire        wr_24  = wr_q & (wadr_q == `CHG_A_WAKE_IRQ);
    wire        pend   = (|(flags_q & ~smask_q)) | (|(BOOST_FAULT & ~bmask_q));

    // two-wire slave; bits sampled on clock rise, driven after its fall
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= S_IDLE;  scl_q <= 1'b1;  sda_q <= 1'b1;
            bitc_q <= 3'h0;  sh_q <= 8'h00;  ptr_q <= 8'h00;
            done_q <= 1'b0;  rw_q <= 1'b0;   first_q <= 1'b0;
            SDA_O <= 1'b0;   SDA_OE <= 1'b0;
            wr_q <= 1'b0;    rd_q <= 1'b0;
            wdat_q <= 8'h00; wadr_q <= 8'h00;
        end else begin
            scl_q <= SCL;
            sda_q <= SDA_I;
            SDA_O <= 1'b0;          // open drain: only ever pulls low
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (start) begin
                st_q <= S_ADDR;
                bitc_q <= 3'h0;
                done_q <= 1'b0;
                SDA_OE <= 1'b0;
            end else if (stop) begin
                st_q <= S_IDLE;
                SDA_OE <= 1'b0;
            end else if (rise) begin
                if (st_q == S_ADDR || st_q == S_WDAT) begin
                    sh_q <= {sh_q[6:0], SDA_I};
                    bitc_q <= bitc_q + 3'h1;
                    done_q <= (bitc_q == 3'h7);
                end else if (st_q == S_RDAT) begin
                    sh_q <= {sh_q[6:0], 1'b0};
                    bitc_q <= bitc_q + 3'h1;
                    done_q <= (bitc_q == 3'h7);
                end else if (st_q == S_RACK && SDA_I) begin
                    st_q <= S_IDLE;     // master nack ends the read
                end
            end else if (fall) begin
                case (st_q)
                    S_ADDR: begin
                        if (done_q && sh_q[7:1] == DEV_ADDR) begin
                            st_q <= S_AACK;
                            rw_q <= sh_q[0];
                            first_q <= ~sh_q[0];
                            SDA_OE <= 1'b1;
                        end else if (done_q) begin
                            st_q <= S_IDLE;
                        end
                    end
                    S_WDAT: begin
                        if (done_q) begin
                            st_q <= S_WACK;
                            SDA_OE <= 1'b1;
                            if (first_q) begin
                                ptr_q <= sh_q;
                            end else begin
                                wr_q <= 1'b1;
                                wadr_q <= ptr_q;
                                wdat_q <= sh_q;
                                ptr_q <= ptr_q + 8'h01;
                            end
                            first_q <= 1'b0;
                        end
                    end
                    S_AACK, S_RACK: begin
                        bitc_q <= 3'h0;
                        done_q <= 1'b0;
                        if (rw_q) begin
                            st_q <= S_RDAT;
                            sh_q <= rdata;
                            SDA_OE <= ~rdata[7];
                            rd_q <= 1'b1;   // byte handed out: read side effects
                            wadr_q <= ptr_q;
                            ptr_q <= ptr_q + 8'h01;
                        end else begin
                            st_q <= S_WDAT;
                            SDA_OE <= 1'b0;
                        end
                    end
                    S_WACK: begin
                        st_q <= S_WDAT;
                        bitc_q <= 3'h0;
                        done_q <= 1'b0;
                        SDA_OE <= 1'b0;
                    end
                    S_RDAT: begin
                        if (done_q) begin
                            st_q <= S_RACK;
                            SDA_OE <= 1'b0;
                        end else begin
                            SDA_OE <= ~sh_q[7];
                        end
                    end
                    default: st_q <= st_q;
                endcase
            end
        end
    end

    // read data; reserved bits read zero
    always @* begin
        case (ptr_q)
            `CHG_A_BST_MASK:   rdata = {bmask_q, 5'h00};            // see R1
            `CHG_A_DETECT:     rdata = {type_q, lsel_q, det2_q, det1_q,
                                        run_q};                     // see R22
            `CHG_A_POWER_PATH: rdata = {1'b0, ppsel_q, ppen_q, mivrdis_q,
                                        mivrlvl_q};
            `CHG_A_SAFETY_DP:  rdata = {1'b0, dprel_q, fc_q, prc_q,
                                        hold_q};                    // see R4
            `CHG_A_ICL:        rdata = icl_q;
            `CHG_A_WAKE_IRQ:   rdata = {eoc_q, wk_q, wken_q, rem_q, rel_q};
            `CHG_A_WATCHDOG:   rdata = {wden_q, 2'h0, wdrst_q, 2'h0, wdp_q};
            `CHG_A_STAT_FLAGS: rdata = {flags_q, 2'h0};
            `CHG_A_STAT_MASK:  rdata = {smask_q, 2'h0};             // see R20
            default:           rdata = 8'h00;
        endcase
    end

    // defaults shared by reset and watchdog restore
    task load_defaults;
        begin
            bmask_q <= R0D[7:5];
            lsel_q <= R0E[4:3];  det2_q <= R0E[2];  det1_q <= R0E[1];
            ppsel_q <= R21[6];   ppen_q <= R21[5];                  // see R2
            mivrdis_q <= R21[4]; mivrlvl_q <= R21[3:0];
            fc_q <= R22[5:3];    prc_q <= R22[2:1];  hold_q <= R22[0];
            icl_q <= `CHG_RST_ICL;
            eoc_q <= R24[7:6];   wk_q <= R24[5:3];   wken_q <= R24[2];
            rem_q <= R24[1];
            wden_q <= R25[7];    wdrst_q <= R25[4];  wdp_q <= R25[1:0];
            smask_q <= 6'h00;
        end
    endtask

    // software-written fields
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            load_defaults;
        end else if (restore_q) begin
            load_defaults;                                          // see R15
        end else if (wr_q) begin
            case (wadr_q)
                `CHG_A_BST_MASK:   bmask_q <= wdat_q[7:5];          // see R1
                `CHG_A_DETECT: begin
                    lsel_q <= wdat_q[4:3];
                    det2_q <= wdat_q[2];
                    det1_q <= wdat_q[1];
                end
                `CHG_A_POWER_PATH: begin
                    ppsel_q <= wdat_q[6];
                    ppen_q <= wdat_q[5];
                    mivrdis_q <= wdat_q[4];
                    mivrlvl_q <= wdat_q[3:0];
                end
                `CHG_A_SAFETY_DP: begin
                    fc_q <= wdat_q[5:3];
                    prc_q <= wdat_q[2:1];
                    hold_q <= wdat_q[0];
                end
                `CHG_A_ICL:        icl_q <= wdat_q;                 // see R8
                `CHG_A_WAKE_IRQ: begin
                    eoc_q <= wdat_q[7:6];
                    wk_q <= wdat_q[5:3];
                    wken_q <= wdat_q[2];
                    rem_q <= wdat_q[1];
                end
                `CHG_A_WATCHDOG: begin
                    wden_q <= wdat_q[7];
                    wdrst_q <= wdat_q[4];
                    wdp_q <= wdat_q[1:0];
                end
                `CHG_A_STAT_MASK:  smask_q <= wdat_q[7:2];          // see R20
                default: ;
            endcase
        end
    end

    // status change flags, one per source; set wins over read-clear
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
            assign set[gi] = armed_q & (inputs[gi] ^ prev_q[gi]); // see R17
            always @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    flags_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    prev_q[gi] <= inputs[gi];
                    flags_q[gi] <= set[gi] | (flags_q[gi] & ~svc); // see R18
                end
            end
        end
    endgenerate

    // timer limits in ms, from the selected codes
    always @* begin
        fc_lim   = (`CHG_FC_BASE_HRS + `CHG_FC_STEP_HRS * fc_q)
                   * `CHG_HOUR_MS;                                  // see R5
        case (prc_q)
            2'h0:    pre_lim = 30 * `CHG_MIN_MS;                    // see R6
            2'h1:    pre_lim = 45 * `CHG_MIN_MS;
            default: pre_lim = 60 * `CHG_MIN_MS;
        endcase
        case (eoc_q)
            2'h0:    back_lim = 0;                                  // see R9
            2'h1:    back_lim = 30 * `CHG_MIN_MS;
            2'h2:    back_lim = 45 * `CHG_MIN_MS;
            default: back_lim = 60 * `CHG_MIN_MS;
        endcase
        if (wk_q < 3'h5)
            wake_lim = (`CHG_WAKE_BASE_S << wk_q) * `CHG_SEC_MS;   // see R10
        else
            wake_lim = (`CHG_WAKE_LONG_S << (wk_q - 3'h5)) * `CHG_SEC_MS;
        wdt_lim  = (`CHG_WDT_BASE_S << wdp_q) * `CHG_SEC_MS;       // see R16
        rst_lim  = wdrst_q ? `CHG_WDT_LONG_MS : `CHG_WDT_SHORT_MS; // see R15
    end

    // millisecond tick and timers; long counts advance only on the tick
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pre_q <= 15'h0;  tick_q <= 1'b0;  armed_q <= 1'b0;
            safe_q <= 26'h0; back_q <= 26'h0; wake_q <= 26'h0;
            wdt_q <= 26'h0;  rmd_q <= 26'h0;  phase_q <= 1'b0;
            wdwait_q <= 1'b0; restore_q <= 1'b0;
            SAFETY_EXPIRED <= 1'b0; BACK_CHARGE_ON <= 1'b0;
            WAKE_EVENT <= 1'b0; WATCHDOG_EXPIRED <= 1'b0;
        end else begin
            armed_q <= 1'b1;
            tick_q <= (pre_q == MS_LAST[14:0]);
            pre_q <= (pre_q == MS_LAST[14:0]) ? 15'h0 : pre_q + 15'h1;
            restore_q <= 1'b0;
            WAKE_EVENT <= 1'b0;
            WATCHDOG_EXPIRED <= 1'b0;
            // safety timer restarts when the charge phase changes
            phase_q <= CHG_FAST;
            if (!(CHG_PRE | CHG_FAST) || phase_q != CHG_FAST)
                safe_q <= 26'h0;
            else if (tick_q && !hold_q)                             // see R7
                safe_q <= safe_q + 26'h1;
            SAFETY_EXPIRED <= CHG_FAST ? (fc_q != `CHG_FC_NONE_CODE &&
                              safe_q >= fc_lim[25:0])
                            : (CHG_PRE && safe_q >= pre_lim[25:0]);
            // back charge runs for the chosen time after termination
            if (!CHG_TERMINATED)
                back_q <= 26'h0;
            else if (tick_q && back_q < back_lim[25:0])
                back_q <= back_q + 26'h1;
            BACK_CHARGE_ON <= CHG_TERMINATED &&
                              back_q < back_lim[25:0];              // see R9
            // periodic wake
            if (!wken_q) begin
                wake_q <= 26'h0;                                    // see R11
            end else if (tick_q) begin
                if (wake_q + 26'h1 >= wake_lim[25:0]) begin
                    wake_q <= 26'h0;
                    WAKE_EVENT <= 1'b1;
                end else begin
                    wake_q <= wake_q + 26'h1;
                end
            end
            // watchdog: bus writes kick it; expiry, wait, then restore
            if (!wden_q || (wr_q && !wdwait_q)) begin
                wdt_q <= 26'h0;                                     // see R14
                wdwait_q <= 1'b0;
            end else if (tick_q) begin
                wdt_q <= wdt_q + 26'h1;
                if (!wdwait_q && wdt_q + 26'h1 >= wdt_lim[25:0]) begin
                    wdwait_q <= 1'b1;
                    wdt_q <= 26'h0;
                    WATCHDOG_EXPIRED <= 1'b1;
                end else if (wdwait_q &&
                             wdt_q + 26'h1 >= rst_lim[25:0]) begin
                    restore_q <= 1'b1;                              // see R15
                    wdwait_q <= 1'b0;
                    wdt_q <= 26'h0;
                end
            end
        end
    end

    // detection, dp source, interrupt pin and its release and reminder
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            run_q <= 1'b0;     type_q <= 3'h0;    DET_START <= 1'b0;
            dprel_q <= 1'b0;   DP_SOURCE_ON <= 1'b1;
            rel_q <= 1'b0;     pin_rel_q <= 1'b0;
            rmd_off_q <= 1'b0; IRQ_N <= 1'b1;     PP_CTRL_OUT <= 1'b0;
        end else begin
            DET_START <= 1'b0;
            if (wr_0e && (wdat_q[`CHG_B_PRI_DETECT] |
                          wdat_q[`CHG_B_SEC_DETECT])) begin
                run_q <= 1'b1;                                      // see R22
                DET_START <= 1'b1;
                dprel_q <= 1'b0;       // new detection drives dp again
            end else if (DET_DONE && run_q) begin
                run_q <= 1'b0;
                type_q <= DET_TYPE;
            end
            if (wr_22 && wdat_q[`CHG_B_DP_RELEASE])
                dprel_q <= 1'b1;                                    // see R3
            DP_SOURCE_ON <= ~dprel_q;                               // see R4
            PP_CTRL_OUT <= ppsel_q ? HW_PP_CTRL : ppen_q;           // see R2
            // release holds pin off until a fresh event; set wins
            if (wr_24 && wdat_q[`CHG_B_IRQ_RELEASE]) begin
                rel_q <= 1'b1;
                pin_rel_q <= 1'b1;
            end else if (rel_q && IRQ_N) begin
                rel_q <= 1'b0;                                      // see R13
            end
            if (|set)
                pin_rel_q <= 1'b0;
            // reminder: unserviced pin drops for 2 ms, then returns
            if (!rem_q || !pend || pin_rel_q || svc) begin
                rmd_q <= 26'h0;
                rmd_off_q <= 1'b0;
            end else if (tick_q) begin
                rmd_q <= rmd_q + 26'h1;
                if (!rmd_off_q && rmd_q + 26'h1 >= `CHG_REMIND_WAIT_MS) begin
                    rmd_off_q <= 1'b1;                              // see R12
                    rmd_q <= 26'h0;
                end else if (rmd_off_q &&
                             rmd_q + 26'h1 >= `CHG_REMIND_OFF_MS) begin
                    rmd_off_q <= 1'b0;
                    rmd_q <= 26'h0;
                end
            end
            IRQ_N <= ~(pend & ~pin_rel_q & ~rmd_off_q & ~(wr_24 &
                     wdat_q[`CHG_B_IRQ_RELEASE]));                  // see R21
        end
    end
endmodule // chg_regs

// *** chg_regs_asserts.sv ***
// port checks for the charger register bank
module chg_regs_asserts (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic SCL,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic DET_START,
    input wire logic DP_SOURCE_ON,
    input wire logic WAKE_EVENT,
    input wire logic WATCHDOG_EXPIRED
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // open drain, the line is only ever pulled low
    property p_sda_low; SDA_O == 1'b0; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda driven high");
    // a bit put on the line holds through the high clock phase
    property p_ack_stands; $rose(SDA_OE) |-> SDA_OE[*3]; endproperty
    a_ack_stands: assert property (p_ack_stands) else $error("sda short");
    property p_scl_high; SCL && $past(SCL) |-> $stable(SDA_OE); endproperty
    a_scl_high: assert property (p_scl_high) else $error("sda moved");
    property p_det_pulse; DET_START |=> !DET_START; endproperty
    a_det_pulse: assert property (p_det_pulse)
        else $error("detect start too long");
    property p_det_dp; DET_START |-> ##[0:1] DP_SOURCE_ON; endproperty
    a_det_dp: assert property (p_det_dp)
        else $error("dp source not re-engaged");
    // once released the source stays off until a new detection
    property p_dp_hold; !DP_SOURCE_ON && !DET_START |=> !DP_SOURCE_ON;
    endproperty
    a_dp_hold: assert property (p_dp_hold)
        else $error("dp source came back");
    property p_wake_gap; WAKE_EVENT |=> !WAKE_EVENT[*8]; endproperty
    a_wake_gap: assert property (p_wake_gap)
        else $error("wake pulses too close");
    property p_wdt_gap; WATCHDOG_EXPIRED |=> !WATCHDOG_EXPIRED[*8];
    endproperty
    a_wdt_gap: assert property (p_wdt_gap)
        else $error("watchdog pulses too close");
endmodule // chg_regs_asserts

bind chg_regs chg_regs_asserts u_chk (.*);

// *** chg_host.sv ***
// two-wire bus host model for the charger register bank
module chg_host (
    input  wire logic CLK,
    input  wire logic SDA,
    output logic      SCL,
    output logic      SDA_PULL
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] DEV = 7'h2a; // arbitrary, matches design default
    int ack_err = 0;
    // idle bus: clock high, data released to the pull-up
    initial begin
        SCL = 1'b1;
        SDA_PULL = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // data moves one cycle after the clock fall, never beside it
    task automatic bit_io(input logic b, output logic s);
        SDA_PULL = ~b;
        wt(2);
        SCL = 1'b1;
        wt(2);
        s = SDA;
        wt(1);
        SCL = 1'b0;
        wt(1);
    endtask
    task automatic go(input logic rs);
        if (rs) begin
            wt(2);
            SCL = 1'b1;
            wt(2);
        end
        SDA_PULL = 1'b1;
        wt(2);
        SCL = 1'b0;
        wt(1);
    endtask
    task automatic stop();
        SDA_PULL = 1'b1;
        wt(2);
        SCL = 1'b1;
        wt(2);
        SDA_PULL = 0;
        wt(2);
    endtask
    task automatic xfer(input logic [7:0] d, input logic r,
                        output logic [7:0] q);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            q[i] = s;
        end
        bit_io(1'b1, s);               // release, or nack the only read byte
        if (!r && s !== 1'b0) ack_err++;
    endtask
    task automatic wr(input logic [7:0] a, d);
        logic [7:0] q;
        go(1'b0);
        xfer({DEV, 1'b0}, 1'b0, q);
        xfer(a, 1'b0, q);
        xfer(d, 1'b0, q);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        go(1'b0);
        xfer({DEV, 1'b0}, 1'b0, q);
        xfer(a, 1'b0, q);
        go(1'b1);
        xfer({DEV, 1'b1}, 1'b0, q);
        xfer(8'hff, 1'b1, q);
        stop();
    endtask
endmodule // chg_host

// *** chg_regs_test.sv ***
// self-checking bench for the charger register bank
module chg_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       CLK = 0, RSTN = 0, SCL, SDA_I, SDA_O, SDA_OE, pull, IRQ_N;
    logic       BT_HOT = 0, BT_WARM = 0, BT_COOL = 0, BT_COLD = 0;
    logic       PWR_GOOD = 0, VREG_ACTIVE = 0, HW_PP_CTRL = 1, DET_DONE = 0;
    logic       CHG_PRE = 0, CHG_FAST = 0, CHG_TERMINATED = 0, DET_START;
    logic [2:0] BOOST_FAULT = 0, DET_TYPE = 0;
    logic       PP_CTRL_OUT, DP_SOURCE_ON, SAFETY_EXPIRED, BACK_CHARGE_ON;
    logic       WAKE_EVENT, WATCHDOG_EXPIRED;
    int         fail_count = 0, check_count = 0, cyc = 0, n;
    logic [15:0] rt [10] = '{16'h0d00, 16'h0e16, 16'h2140, 16'h2200,
        16'h232f, 16'h2400, 16'h2513, 16'h2600, 16'h2700, 16'h3000};
    chg_regs #(.MS_CYCLES(4)) uut (.*);
    chg_host host (.CLK(CLK), .SDA(SDA_I), .SCL(SCL), .SDA_PULL(pull));
    // wired-and data line with pull-up
    assign SDA_I = ~(pull | (SDA_OE & ~SDA_O));
    always #20 CLK = ~CLK;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // runaway guard, the sequence needs about 70000 cycles
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            print_verdict;
        end
    end
    task automatic chk(input logic [7:0] s, e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic pin(input logic s, e);
        chk({7'h0, s}, {7'h0, e});
    endtask
    task automatic rc(input logic [7:0] a, e);
        logic [7:0] q;
        host.rd(a, q);
        chk(q, e);
    endtask
    // bounded wait, n reaches 20000 when the level never comes
    task automatic till(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 20000) begin
            @(negedge CLK);
            n++;
        end
    endtask
    initial begin
        repeat (3) @(negedge CLK);
        RSTN = 1'b1;
        repeat (2) @(negedge CLK);
        for (int i = 0; i < 10; i++) rc(rt[i][15:8], rt[i][7:0]);
        pin(PP_CTRL_OUT, 1'b1);
        host.wr(8'h21, 8'h00);
        pin(PP_CTRL_OUT, 1'b0);
        $display("test reset values done");
        host.wr(8'h23, 8'h53);
        host.wr(8'h25, 8'h80);
        till(WATCHDOG_EXPIRED, 1'b1, n);
        pin(n >= 3975 && n <= 4000, 1'b1);
        repeat (850) @(negedge CLK);
        rc(8'h23, 8'h2f);
        rc(8'h25, 8'h13);
        host.wr(8'h24, 8'h04);
        till(WAKE_EVENT, 1'b1, n);
        till(WAKE_EVENT, 1'b0, n);
        till(WAKE_EVENT, 1'b1, n);
        pin(n == 15999, 1'b1);
        host.wr(8'h24, 8'h00);
        till(WAKE_EVENT, 1'b1, n);
        pin(n == 20000, 1'b1);
        $display("test timers done");
        host.wr(8'h24, 8'h02);
        BT_HOT = 1'b1;
        till(IRQ_N, 1'b0, n);
        till(IRQ_N, 1'b1, n);
        till(IRQ_N, 1'b0, n);
        pin(n == 8, 1'b1);
        rc(8'h26, 8'h80);
        pin(IRQ_N, 1'b1);
        host.wr(8'h24, 8'h00);
        host.wr(8'h27, 8'hfc);
        BT_WARM = 1'b1;
        repeat (4) @(negedge CLK);
        pin(IRQ_N, 1'b1);
        rc(8'h27, 8'hfc);
        rc(8'h26, 8'h40);
        host.wr(8'h27, 8'h00);
        PWR_GOOD = 1'b1;
        VREG_ACTIVE = 1'b1;
        repeat (4) @(negedge CLK);
        pin(IRQ_N, 1'b0);
        rc(8'h26, 8'h0c);
        BOOST_FAULT = 3'b010;
        repeat (4) @(negedge CLK);
        pin(IRQ_N, 1'b0);
        host.wr(8'h0d, 8'he0);
        pin(IRQ_N, 1'b1);
        rc(8'h0d, 8'he0);
        BT_COOL = 1'b1;
        repeat (4) @(negedge CLK);
        pin(IRQ_N, 1'b0);
        host.wr(8'h24, 8'h01);
        pin(IRQ_N, 1'b1);
        rc(8'h24, 8'h00);
        rc(8'h26, 8'h20);
        $display("test interrupts done");
        host.wr(8'h22, 8'h80);
        pin(DP_SOURCE_ON, 1'b0);
        rc(8'h22, 8'h40);
        host.wr(8'h22, 8'h00);
        pin(DP_SOURCE_ON, 1'b0);
        host.wr(8'h0e, 8'h16);
        pin(DP_SOURCE_ON, 1'b1);
        rc(8'h0e, 8'h17);
        DET_TYPE = 3'b101;
        DET_DONE = 1'b1;
        @(negedge CLK);
        DET_DONE = 1'b0;
        rc(8'h0e, 8'hb6);
        host.wr(8'h22, 8'h2b);
        rc(8'h22, 8'h2b);
        host.wr(8'h23, 8'hfb);
        rc(8'h23, 8'hfb);
        host.wr(8'h24, 8'he0);
        CHG_TERMINATED = 1'b1;
        rc(8'h24, 8'he0);
        pin(BACK_CHARGE_ON, 1'b1);
        host.wr(8'h26, 8'hfc);
        rc(8'h26, 8'h00);
        chk(8'(host.ack_err), 8'h00);
        $display("test fields done");
        print_verdict;
    end
endmodule // chg_regs_test
